// ### logic/io_port_set.sv
// Four I/O ports (8,8,8,2 bits) with per-pin driver type, latch, filtered input.
// Assumes pad cells resolve strong/weak drive from the enables given here.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module io_port_set (
	input wire logic mclk_i, // System clock 40 MHz
	input wire logic sys_rst_i, // Synchronous reset, high
	input wire logic clk_en_i, // Freezes all state when low
	input wire logic [3:0] reg_addr_i, // Register index
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
	input wire logic [25:0] pad_in_i, // Pad levels, port0..3 packed
	output logic [25:0] pad_strong_hi_o, // Strong pull-up enable
	output logic [25:0] pad_weak_hi_o, // Weak pull-up enable
	output logic [25:0] pad_pull_lo_o, // Pull-down enable
	output logic [25:0] pad_oe_o, // Any driver active
	output logic [7:0] port0_digital_input_disable_o // Digital input buffer disable
);
	localparam int NPIN = 26;
	logic [7:0] latch_ff [4];
	logic [7:0] cfga_ff [4];
	logic [7:0] cfgb_ff [4];
	logic [7:0] dig_dis_ff;
	logic [7:0] rdata_ff;
	logic [NPIN-1:0] filt;
	logic [NPIN-1:0] pin_in;
	logic [NPIN-1:0] lat_flat, a_flat, b_flat;

	// Register decode
	wire logic wr_latch = reg_wr_i && (reg_addr_i[3:2] == 2'b00);
	wire logic wr_cfga = reg_wr_i && (reg_addr_i[3:2] == 2'b10);
	wire logic wr_cfgb = reg_wr_i && (reg_addr_i[3:2] == 2'b11) && (reg_addr_i != io_port_pkg::OFF_DIG_DIS);
	wire logic wr_dis = reg_wr_i && (reg_addr_i == io_port_pkg::OFF_DIG_DIS);
	wire logic [1:0] sel = reg_addr_i[1:0];
	// Port 3 is only 2 bits; port 1 restricted pins get filtered write values
	wire logic [7:0] wmask = (sel == 2'd3) ? io_port_pkg::PORT3_MASK : 8'hFF;

	// Restricted pins: reset pin held input-only; serial pins forced to cfgb=1
	function automatic logic [7:0] fix_a(input logic [1:0] p, input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (p == 2'd1) begin
			r[io_port_pkg::PIN_RST] = 1'b0;
			r[io_port_pkg::PIN_SCL] = v[io_port_pkg::PIN_SCL];
		end
		return r;
	endfunction : fix_a

	function automatic logic [7:0] fix_b(input logic [1:0] p, input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (p == 2'd1) begin
			r[io_port_pkg::PIN_RST] = 1'b1;
			r[io_port_pkg::PIN_SCL] = 1'b1;
			r[io_port_pkg::PIN_SDA] = 1'b1;
		end
		return r;
	endfunction : fix_b

	// Latch and config registers; reset leaves every pin input-only
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++) begin
				// Port 3 has only two live bits; its unused latch bits must read zero
				latch_ff[i] <= (i == 3) ? (io_port_pkg::RST_LATCH & io_port_pkg::PORT3_MASK) : io_port_pkg::RST_LATCH;
				cfga_ff[i] <= io_port_pkg::RST_CFGA;
				cfgb_ff[i] <= io_port_pkg::RST_CFGB;
			end
			dig_dis_ff <= io_port_pkg::RST_DIG_DIS;
		end else if (clk_en_i) begin
			if (wr_latch) begin
				latch_ff[sel] <= reg_wdata_i & wmask;
			end
			if (wr_cfga) begin
				cfga_ff[sel] <= fix_a(sel, reg_wdata_i & wmask);
			end
			if (wr_cfgb) begin
				cfgb_ff[sel] <= fix_b(sel, reg_wdata_i | ~wmask);
			end
			if (wr_dis) begin
				dig_dis_ff <= reg_wdata_i & io_port_pkg::DIG_DIS_MASK;
			end
		end
	end

	// Flatten registers onto the 26 pins
	assign lat_flat = {latch_ff[3][1:0], latch_ff[2], latch_ff[1], latch_ff[0]};
	assign a_flat = {cfga_ff[3][1:0], cfga_ff[2], cfga_ff[1], cfga_ff[0]};
	assign b_flat = {cfgb_ff[3][1:0], cfgb_ff[2], cfgb_ff[1], cfgb_ff[0]};

	// Per pin: input filter and driver decode
	generate
		for (genvar g = 0; g < NPIN; g++) begin : g_pin
			wire logic [1:0] mode = {b_flat[g], a_flat[g]};
			wire logic is_q = (mode == io_port_pkg::MODE_QUASI);
			wire logic is_p = (mode == io_port_pkg::MODE_PUSH);
			wire logic is_o = (mode == io_port_pkg::MODE_OPEN);
			pin_input_filter u_filt (
				.mclk_i(mclk_i),
				.sys_rst_i(sys_rst_i),
				.clk_en_i(clk_en_i),
				.pin_i(pad_in_i[g]),
				.level_o(filt[g])
			);
			// Low drive common to quasi, push-pull, open-drain; input-only drives nothing
			assign pad_pull_lo_o[g] = (is_q || is_p || is_o) && !lat_flat[g];
			assign pad_weak_hi_o[g] = is_q && lat_flat[g];
			assign pad_strong_hi_o[g] = is_p && lat_flat[g];
			assign pad_oe_o[g] = pad_pull_lo_o[g] || pad_weak_hi_o[g] || pad_strong_hi_o[g];
			// Disabled digital inputs read zero
			if (g >= 1 && g <= 5) begin : g_dis
				assign pin_in[g] = filt[g] && !dig_dis_ff[g];
			end else begin : g_nodis
				assign pin_in[g] = filt[g];
			end
		end
	endgenerate

	// Read mux
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr_i)
			io_port_pkg::OFF_LATCH0: rd_mux = latch_ff[0];
			io_port_pkg::OFF_LATCH1: rd_mux = latch_ff[1];
			io_port_pkg::OFF_LATCH2: rd_mux = latch_ff[2];
			io_port_pkg::OFF_LATCH3: rd_mux = latch_ff[3];
			io_port_pkg::OFF_PIN0: rd_mux = pin_in[7:0];
			io_port_pkg::OFF_PIN1: rd_mux = pin_in[15:8];
			io_port_pkg::OFF_PIN2: rd_mux = pin_in[23:16];
			io_port_pkg::OFF_PIN3: rd_mux = {6'h00, pin_in[25:24]};
			4'h8, 4'h9, 4'hA, 4'hB: rd_mux = cfga_ff[sel];
			4'hC, 4'hD, 4'hE: rd_mux = cfgb_ff[sel];
			io_port_pkg::OFF_DIG_DIS: rd_mux = dig_dis_ff;
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_ff <= 8'h00;
		end else if (clk_en_i) begin
			rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata_o = rdata_ff;
	assign port0_digital_input_disable_o = dig_dis_ff;

	// Checks
	a_rst_pin_input: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!pad_oe_o[8 + io_port_pkg::PIN_RST]) else $error("reset-shared pin drives");
	a_serial_no_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!(pad_weak_hi_o[10] || pad_strong_hi_o[10] || pad_weak_hi_o[11] || pad_strong_hi_o[11]))
		else $error("serial pin drives high");
	a_open_low_only: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(b_flat[0] && a_flat[0]) |-> (!pad_weak_hi_o[0] && !pad_strong_hi_o[0] && (pad_pull_lo_o[0] == !lat_flat[0])))
		else $error("open-drain drive wrong");
	a_input_hiz: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(b_flat[4] && !a_flat[4]) |-> !pad_oe_o[4]) else $error("input-only pin drives");
	a_push_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(!b_flat[16] && a_flat[16] && lat_flat[16]) |-> pad_strong_hi_o[16]) else $error("push-pull high missing");
	a_quasi_weak: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(!b_flat[17] && !a_flat[17]) |-> (pad_weak_hi_o[17] == lat_flat[17] && !pad_strong_hi_o[17]))
		else $error("quasi drive wrong");
	a_reset_input: assert property (@(posedge mclk_i)
		$past(sys_rst_i) |-> (pad_oe_o == '0 && dig_dis_ff == 8'h00)) else $error("reset state not input-only");
	a_dis_cfg_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(clk_en_i && wr_dis) |=> (dig_dis_ff == ($past(reg_wdata_i) & 8'h3E))) else $error("disable write lost");
	a_port3_width: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		latch_ff[3][7:2] == 6'h00) else $error("port 3 upper bits set");

	// Port 3 type bits above its width never take part in a decode
	a_port3_cfg_masked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cfga_ff[3][7:2] == 6'h00)
		else $error("port 3 upper config bits set");

	// Restricted pins keep their forced type bits whatever software wrote
	a_restrict_cfg: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		b_flat[8 + io_port_pkg::PIN_RST] && !a_flat[8 + io_port_pkg::PIN_RST])
		else $error("reset-shared pin type changed");
	a_serial_cfg: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		b_flat[8 + io_port_pkg::PIN_SCL] && b_flat[8 + io_port_pkg::PIN_SDA])
		else $error("serial pin type allows high drive");

	// Only bits 1 to 5 of the disable register may ever be set
	a_dis_bits_only: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(dig_dis_ff & ~io_port_pkg::DIG_DIS_MASK) == 8'h00)
		else $error("disable bit outside range set");

	// A disabled digital input must read as zero on the pin register path
	a_dis_reads_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(pin_in[5:1] & dig_dis_ff[5:1]) == 5'h00)
		else $error("disabled input still visible");

	// Read data stands for one cycle only, then the port idles at zero
	a_rdata_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(clk_en_i && !reg_rd_i) |=> (reg_rdata_o == 8'h00))
		else $error("read data held too long");

	// With the enable low nothing in the register file may move
	a_freeze_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!clk_en_i |=> ($stable(lat_flat) && $stable(a_flat) && $stable(b_flat)
		&& $stable(dig_dis_ff) && $stable(reg_rdata_o)))
		else $error("state moved while frozen");

	// Every pin, not only the sample pins above: the pad enables must agree
	// with each other, otherwise a pad cell could fight itself
	generate
		for (genvar c = 0; c < NPIN; c++) begin : g_chk
			wire logic [1:0] cmode = {b_flat[c], a_flat[c]};
			// Pull-down and any pull-up never on together
			a_pin_no_fight: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				!(pad_pull_lo_o[c] && (pad_weak_hi_o[c] || pad_strong_hi_o[c])))
				else $error("pin drives both ways");
			// Input-only pins leave every driver off
			a_pin_input_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				(cmode == io_port_pkg::MODE_INPUT) |-> !pad_oe_o[c])
				else $error("input-only pin drives");
			// Open-drain pins never pull up at all
			a_pin_open_noup: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				(cmode == io_port_pkg::MODE_OPEN) |-> !(pad_weak_hi_o[c] || pad_strong_hi_o[c]))
				else $error("open-drain pin pulls up");
			// Output enable is exactly the union of the three drivers
			a_pin_oe_sum: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
				pad_oe_o[c] == (pad_pull_lo_o[c] || pad_weak_hi_o[c] || pad_strong_hi_o[c]))
				else $error("output enable mismatch");
		end
	endgenerate
endmodule : io_port_set
`default_nettype wire

// ### logic/io_port_pkg.sv
// Constants for the configurable I/O port set: register map, field codes, reset values.
// Assumes a single 40 MHz clock domain and a plain strobe register port.
`default_nettype none
package io_port_pkg;
	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam int NUM_PORTS = 4;
	localparam int PORT3_W = 2;
	// Register offsets (word index on the plain port)
	localparam logic [3:0] OFF_LATCH0 = 4'h0;
	localparam logic [3:0] OFF_LATCH1 = 4'h1;
	localparam logic [3:0] OFF_LATCH2 = 4'h2;
	localparam logic [3:0] OFF_LATCH3 = 4'h3;
	localparam logic [3:0] OFF_PIN0 = 4'h4;
	localparam logic [3:0] OFF_PIN1 = 4'h5;
	localparam logic [3:0] OFF_PIN2 = 4'h6;
	localparam logic [3:0] OFF_PIN3 = 4'h7;
	localparam logic [3:0] OFF_CFGA_BASE = 4'h8;
	localparam logic [3:0] OFF_CFGB_BASE = 4'hC;
	// Digital input disable for port 0 takes the port 3 cfgb slot at 0xF
	localparam logic [3:0] OFF_DIG_DIS = 4'hF;
	// Driver-type encoding {cfgb,cfga}
	localparam logic [1:0] MODE_QUASI = 2'h0;
	localparam logic [1:0] MODE_PUSH = 2'h1;
	localparam logic [1:0] MODE_INPUT = 2'h2;
	localparam logic [1:0] MODE_OPEN = 2'h3;
	// Reset values: input-only means cfga=0, cfgb=1
	localparam logic [7:0] RST_CFGA = 8'h00;
	localparam logic [7:0] RST_CFGB = 8'hFF;
	localparam logic [7:0] RST_LATCH = 8'hFF;
	localparam logic [7:0] RST_DIG_DIS = 8'h00;
	// Port 0 bits whose digital input may be disabled (bits 1..5)
	localparam logic [7:0] DIG_DIS_MASK = 8'h3E;
	// Port 1 restricted pins
	localparam int PIN_SCL = 2;
	localparam int PIN_SDA = 3;
	localparam int PIN_RST = 5;
	// Port 3 live bits
	localparam logic [7:0] PORT3_MASK = 8'h03;
	// Glitch filter length in cycles; time figure in ns
	localparam int GLITCH_NS = 50;
	localparam int CLK_PERIOD_NS = 25;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_CW = 2;
endpackage : io_port_pkg
`default_nettype wire

// ### logic/pin_input_filter.sv
// One pin input path: three-flop synchroniser, then glitch suppression with hysteresis.
// Assumes the raw pin level is asynchronous to mclk_i.
`default_nettype none
module pin_input_filter (
	input wire logic mclk_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic clk_en_i, // Clock enable
	input wire logic pin_i, // Raw pin level
	output logic level_o // Filtered level
);
	logic s1_ff, s2_ff, s3_ff;
	logic [io_port_pkg::GLITCH_CW-1:0] cnt_ff;
	logic lvl_ff;
	wire logic agree = (s2_ff == s3_ff);
	wire logic differs = agree && (s3_ff != lvl_ff);
	wire logic done = (cnt_ff == io_port_pkg::GLITCH_CW'(io_port_pkg::GLITCH_CYC - 1));
	// Synchroniser; s1 only feeds s2
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else if (clk_en_i) begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
	// New level must persist, so short pulses never flip the output
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cnt_ff <= '0;
			lvl_ff <= 1'b1;
		end else if (clk_en_i) begin
			if (!differs) begin
				cnt_ff <= '0;
			end else if (done) begin
				cnt_ff <= '0;
				lvl_ff <= s3_ff;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end
	assign level_o = lvl_ff;

	// The filtered level may only move after a full stable run of the synced level
	a_filter_steady: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(!$past(sys_rst_i) && $changed(lvl_ff)) |-> ($past(done) && $past(differs) && lvl_ff == $past(s3_ff)))
		else $error("filter level moved early");
endmodule : pin_input_filter
`default_nettype wire

// ### test/pin_circuit_model.sv
// Outside circuitry on the pads: pull-up resistors and optional outside drivers.
// Assumes pad enables from the port set; the device's pull-down and strong high win.
`default_nettype none
module pin_circuit_model (
	input wire logic [25:0] strong_hi_i, // Strong pull-up enable
	input wire logic [25:0] pull_lo_i, // Pull-down enable
	input wire logic [25:0] ext_en_i, // Outside driver active
	input wire logic [25:0] ext_val_i, // Outside driver level
	output logic [25:0] pad_o // Resolved pad level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Resistor to supply gives a high when nobody drives; weak high yields to outside
	assign pad_o = ~pull_lo_i & (strong_hi_i | ~ext_en_i | ext_val_i);
endmodule : pin_circuit_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the I/O port set: register port, pad enables, pin reads.
// Assumes the pad model above; a pin level settles into its read register within 8 cycles.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i, sys_rst_i, reg_wr_i, reg_rd_i, clk_en;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, dd_o, rd_v, dd;
	logic [25:0] pad, shi, whi, plo, oe, ext_en, ext_val, es, el;
	logic [7:0] lat [4], ca [4], cb [4];
	integer seed, err_total, check_count, i, r;

	io_port_set i_io_port_set (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .pad_in_i(pad), .pad_strong_hi_o(shi), .pad_weak_hi_o(whi),
		.pad_pull_lo_o(plo), .pad_oe_o(oe), .port0_digital_input_disable_o(dd_o));
	pin_circuit_model i_pin_circuit_model (.strong_hi_i(shi), .pull_lo_i(plo), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pad_o(pad));

	// Expected driver type, restricted pins coerced
	function automatic logic [1:0] mode(input int n);
		logic [1:0] m;
		m = {cb[n/8][n%8], ca[n/8][n%8]};
		if (n >= 24 || n == 10 || n == 11) m[1] = 1'b1;
		if (n == 13) m = io_port_pkg::MODE_INPUT;
		return m;
	endfunction : mode

	task automatic chk(input logic [25:0] g, input logic [25:0] e, input string m);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask : chk

	// Bus write; the bench's register copy follows the write
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		#1;
		if (a < 4'h4) lat[a[1:0]] = d;
		else if (a == 4'hF) dd = d & io_port_pkg::DIG_DIS_MASK;
		else if (a >= 4'hC) cb[a[1:0]] = d;
		else if (a >= 4'h8) ca[a[1:0]] = d;
	endtask : wr

	// Bus read; data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : rd

	task automatic chk_pads();
		logic [1:0] m;
		logic b;
		logic [25:0] w;
		for (int n = 0; n < 26; n++) begin
			m = mode(n);
			b = lat[n/8][n%8];
			es[n] = (m == io_port_pkg::MODE_PUSH) & b;
			w[n] = (m == io_port_pkg::MODE_QUASI) & b;
			el[n] = (m != io_port_pkg::MODE_INPUT) & ~b;
		end
		chk(shi, es, "strong high");
		chk(whi, w, "weak high");
		chk(plo, el, "pull low");
		chk(oe, es | w | el, "output enable");
		chk({18'h0, dd_o}, {18'h0, dd}, "input disable");
	endtask : chk_pads

	task automatic chk_pin(input int p);
		logic [25:0] lv;
		logic [7:0] e;
		lv = ~el & (es | ~ext_en | ext_val);
		e = 8'(lv >> (8 * p));
		if (p == 3) e = e & 8'h03;
		if (p == 0) e = e & ~dd;
		rd(4'(4 + p), rd_v);
		chk({18'h0, rd_v}, {18'h0, e}, "pin read");
	endtask : chk_pin

	task automatic do_rst();
		sys_rst_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			lat[k] = 8'hFF;
			ca[k] = 8'h00;
			cb[k] = 8'hFF;
		end
		dd = 8'h00;
		#1;
	endtask : do_rst

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// Watchdog, far beyond the roughly 1000 cycles the tests need
	initial begin
		#200us;
		err_total++;
		results();
	end

	initial begin
		seed = 67;
		err_total = 0;
		check_count = 0;
		sys_rst_i = 1'b1;
		clk_en = 1'b1;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		ext_en = 26'h3FF_FFFF;
		ext_val = 26'h0;
		do_rst();
		chk_pads();
		repeat (8) @(posedge mclk_i);
		chk_pin(2);
		// One-cycle glitch must not reach the pin register
		ext_val[16] <= 1'b1;
		@(posedge mclk_i);
		ext_val[16] <= 1'b0;
		repeat (8) @(posedge mclk_i);
		chk_pin(2);
		ext_val[16] <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk_pin(2);
		// Ask push-pull of every port 1 pin; restricted ones must refuse
		wr(4'h9, 8'hFF);
		wr(4'hD, 8'h00);
		chk_pads();
		$display("reset, filter and restricted pin tests done");
		// Random writes to latches, both config registers and the input disable
		for (i = 0; i < 80; i++) begin
			r = $unsigned($random(seed)) % 12;
			wr(4'(r < 4 ? r : r + 4), 8'($random(seed)));
			ext_en <= 26'($random(seed));
			ext_val <= 26'($random(seed));
			repeat (8) @(posedge mclk_i);
			chk_pads();
			chk_pin(r % 4);
		end
		$display("random configuration test done");
		// Enable low: a write must not land; read data then idles at zero
		rd_v = lat[0];
		clk_en <= 1'b0;
		wr(4'h0, ~rd_v);
		lat[0] = rd_v;
		clk_en <= 1'b1;
		rd(4'h0, rd_v);
		chk({18'h0, rd_v}, {18'h0, lat[0]}, "frozen latch");
		@(posedge mclk_i);
		#1;
		chk({18'h0, reg_rdata_o}, 26'h0, "read data idle");
		$display("clock enable test done");
		do_rst();
		chk_pads();
		$display("second reset test done");
		results();
	end
endmodule : tb_top
`default_nettype wire
